/* rtl/rcr_pkg.sv */
// Package: register map, field layout, reset values and carriers
package rcr_pkg;

  // Printed offsets are word indices; byte address is index * 4
  localparam int RCR_ADDR_LSB = 2;
  localparam int RCR_IDX_W = 8;
  localparam logic [7:0] IDX_CH2_CTRL = 8'h22;
  localparam logic [1:0][7:0] IDX_SW_PRI = {8'h40, 8'h30};
  localparam logic [1:0][7:0] IDX_SW_SEC = {8'h41, 8'h31};
  localparam logic [1:0][7:0] IDX_SW_CTRL = {8'h42, 8'h32};
  localparam logic [2:0][7:0] IDX_LDO_LVL = {8'h60, 8'h58, 8'h50};
  localparam logic [2:0][7:0] IDX_LDO_CTRL = {8'h61, 8'h59, 8'h51};
  localparam logic [7:0] IDX_IRQ_STAT = 8'ha0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'ha1;

  // Control and level field positions
  localparam int BIT_EN = 7;
  localparam int BIT_PHASE = 2;
  localparam int BIT_DIS = 2;
  localparam int BIT_UNMASK = 1;
  localparam int BIT_PG = 0;
  localparam int LVL_W = 6;

  // Values after reset
  localparam logic [5:0] RST_LVL = 6'h00;
  localparam logic RST_CTRL_BIT = 1'b0;
  localparam logic RST_HREADY = 1'b1;
  localparam logic RST_SYNC = 1'b0;

  // Pins through the synchroniser: sel, pgood[7:2], fault[7:2]
  localparam int RCR_SYNC_W = 13;

  typedef struct packed {
    logic [RCR_SYNC_W-1:0] s1;
    logic [RCR_SYNC_W-1:0] s2;
    logic [RCR_SYNC_W-1:0] s3;
    logic [RCR_SYNC_W-1:0] stable;
  } rcr_sync_t;

  typedef struct packed {
    logic [7:2] en;
    logic [4:2] phase;
    logic [7:2] unmask;
    logic [7:5] dis;
    logic [1:0][5:0] prim;
    logic [1:0][5:0] sec;
    logic [2:0][5:0] ldo;
  } rcr_cfg_t;

  typedef struct packed {
    logic [7:2] en;
    logic [4:2] phase;
    logic [7:5] discharge;
    logic [1:0][5:0] sw_level;
    logic [2:0][5:0] ldo_level;
  } rcr_drive_t;

  typedef struct packed {
    rcr_cfg_t cfg;
    rcr_drive_t drv;
    logic [5:0] stat;
    logic [5:0] mask;
    logic [5:0] flt_prev;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] hrdata;
    logic hready;
    logic irq;
  } rcr_state_t;

endpackage : rcr_pkg

/* rtl/rcr_regs.sv */
// Regulator channel control and status registers on AHB-Lite
// Functional notes
// - Switchers three and four drive the primary level code while the select pin is low.
// - Switchers three and four drive the secondary level code while the select pin is high.
// - Control bit 7 of every channel is read/write and turns the regulator on or off.
// - Switcher control bit 2 selects 180 degree offset (1) or in-phase (0) switching.
// - Control bit 1 lets a channel's faults raise the interrupt; zero suppresses them.
// - Control bit 0 is read-only and shows the channel's power-good state.
// - Linear channel control bit 2 enables output discharge while that channel is off.
// - Linear channels use one 6-bit level code that ignores the select pin.
`timescale 1ns/100ps
`default_nettype none
module rcr_regs
  import rcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic level_select_pin,
  input wire logic [7:2] pgood_pin,
  input wire logic [7:2] fault_pin,
  output rcr_drive_t drive,
  output logic irq
);

  rcr_state_t st;
  rcr_state_t nxt_st;
  logic [RCR_SYNC_W-1:0] pins_f;
  logic sel_f;
  logic [7:2] pg_f;
  logic [7:2] flt_f;
  logic [5:0] flt_ev;
  logic [5:0] rd_clr;
  logic addr_take;

  rcr_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in({level_select_pin, pgood_pin, fault_pin}),
    .level_out(pins_f)
  );

  assign sel_f = pins_f[12];
  assign pg_f = pins_f[11:6];
  assign flt_f = pins_f[5:0];

  // Word index of a byte address; misaligned or high bits unmapped
  function automatic logic [7:0] word_idx(input logic [31:0] a);
    logic [7:0] r;
    r = 8'hff;
    if (a[31:10] == 22'h000000 && a[1:0] == 2'h0) begin
      r = a[9:2];
    end
    return r;
  endfunction : word_idx

  // Control byte shared by all channels
  function automatic logic [7:0] ctrl_byte(input logic en, input logic b2,
                                           input logic um, input logic pg);
    logic [7:0] v;
    v = 8'h00;
    v[BIT_EN] = en;
    v[BIT_PHASE] = b2;
    v[BIT_UNMASK] = um;
    v[BIT_PG] = pg;
    return v;
  endfunction : ctrl_byte

  function automatic logic [7:0] rd_val(input rcr_cfg_t c, input logic [7:2] pg,
                                        input logic [5:0] s, input logic [5:0] m,
                                        input logic [7:0] i);
    logic [7:0] v;
    v = 8'h00;
    if (i == IDX_CH2_CTRL) begin
      v = ctrl_byte(c.en[2], c.phase[2], c.unmask[2], pg[2]);
    end
    for (int k = 0; k < 2; k++) begin
      if (i == IDX_SW_PRI[k]) begin
        v = {2'h0, c.prim[k]};
      end
      if (i == IDX_SW_SEC[k]) begin
        v = {2'h0, c.sec[k]};
      end
      if (i == IDX_SW_CTRL[k]) begin
        v = ctrl_byte(c.en[k+3], c.phase[k+3], c.unmask[k+3], pg[k+3]);
      end
    end
    for (int k = 0; k < 3; k++) begin
      if (i == IDX_LDO_LVL[k]) begin
        v = {2'h0, c.ldo[k]};
      end
      if (i == IDX_LDO_CTRL[k]) begin
        v = ctrl_byte(c.en[k+5], c.dis[k+5], c.unmask[k+5], pg[k+5]);
      end
    end
    if (i == IDX_IRQ_STAT) begin
      v = {2'h0, s};
    end
    if (i == IDX_IRQ_MASK) begin
      v = {2'h0, m};
    end
    return v;
  endfunction : rd_val

  assign addr_take = hsel && htrans[1] && hready;

  always_comb begin
    nxt_st = st;
    rd_clr = 6'h00;
    // Data phase write; hwdata is valid only now
    if (st.wr_pend) begin
      if (st.wr_idx == IDX_CH2_CTRL) begin
        nxt_st.cfg.en[2] = hwdata[BIT_EN];
        nxt_st.cfg.phase[2] = hwdata[BIT_PHASE];
        nxt_st.cfg.unmask[2] = hwdata[BIT_UNMASK];
      end
      for (int k = 0; k < 2; k++) begin
        if (st.wr_idx == IDX_SW_PRI[k]) begin
          nxt_st.cfg.prim[k] = hwdata[LVL_W-1:0];
        end
        if (st.wr_idx == IDX_SW_SEC[k]) begin
          nxt_st.cfg.sec[k] = hwdata[LVL_W-1:0];
        end
        if (st.wr_idx == IDX_SW_CTRL[k]) begin
          nxt_st.cfg.en[k+3] = hwdata[BIT_EN];
          nxt_st.cfg.phase[k+3] = hwdata[BIT_PHASE];
          nxt_st.cfg.unmask[k+3] = hwdata[BIT_UNMASK];
        end
      end
      for (int k = 0; k < 3; k++) begin
        if (st.wr_idx == IDX_LDO_LVL[k]) begin
          nxt_st.cfg.ldo[k] = hwdata[LVL_W-1:0];
        end
        if (st.wr_idx == IDX_LDO_CTRL[k]) begin
          nxt_st.cfg.en[k+5] = hwdata[BIT_EN];
          nxt_st.cfg.dis[k+5] = hwdata[BIT_DIS];
          nxt_st.cfg.unmask[k+5] = hwdata[BIT_UNMASK];
        end
      end
      if (st.wr_idx == IDX_IRQ_MASK) begin
        nxt_st.mask = hwdata[5:0];
      end
    end
    nxt_st.wr_pend = 1'b0;
    // Address phase; reads see a write finishing this cycle
    if (addr_take) begin
      if (hwrite) begin
        nxt_st.wr_pend = 1'b1;
        nxt_st.wr_idx = word_idx(haddr);
      end else begin
        nxt_st.hrdata = {24'h000000,
          rd_val(nxt_st.cfg, pg_f, st.stat, nxt_st.mask, word_idx(haddr))};
        if (word_idx(haddr) == IDX_IRQ_STAT) begin
          rd_clr = 6'h3f;
        end
      end
    end
    flt_ev = flt_f & ~st.flt_prev & st.cfg.unmask;
    nxt_st.flt_prev = flt_f;
    // Set wins over read-clear
    nxt_st.stat = (st.stat & ~rd_clr) | flt_ev;
    nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
    for (int k = 0; k < 2; k++) begin
      nxt_st.drv.sw_level[k] = sel_f ? nxt_st.cfg.sec[k] : nxt_st.cfg.prim[k];
    end
    nxt_st.drv.ldo_level = nxt_st.cfg.ldo;
    nxt_st.drv.en = nxt_st.cfg.en;
    nxt_st.drv.phase = nxt_st.cfg.phase;
    nxt_st.drv.discharge = nxt_st.cfg.dis & ~nxt_st.cfg.en[7:5];
    nxt_st.hready = RST_HREADY;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.cfg.prim <= {2{RST_LVL}};
      st.cfg.sec <= {2{RST_LVL}};
      st.cfg.ldo <= {3{RST_LVL}};
      st.cfg.en <= {6{RST_CTRL_BIT}};
      st.hready <= RST_HREADY;
    end else begin
      st <= nxt_st;
    end
  end

  // Zero wait states, so the answer is always OKAY
  assign hrdata = st.hrdata;
  assign hreadyout = st.hready;
  assign hresp = 1'b0;
  assign drive = st.drv;
  assign irq = st.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr(logic [7:0] i);
    addr_take && hwrite && word_idx(haddr) == i;
  endsequence

  sequence s_rd(logic [7:0] i);
    addr_take && !hwrite && word_idx(haddr) == i;
  endsequence

  sequence s_quiet2;
    !st.wr_pend [*2];
  endsequence

  a_pri_level_sel: assert property (
    (!sel_f && !st.wr_pend) [*2] |-> drive.sw_level[0] == st.cfg.prim[0]
  ) else $error("primary level not applied with select low");

  a_sec_level_sel: assert property (
    (sel_f && !st.wr_pend) [*2] |-> drive.sw_level[1] == st.cfg.sec[1]
  ) else $error("secondary level not applied with select high");

  a_en_write_on: assert property (
    s_wr(IDX_SW_CTRL[0]) ##1 hwdata[BIT_EN] |=> drive.en[3]
  ) else $error("channel three not enabled after write of one");

  a_en_write_off: assert property (
    s_wr(IDX_LDO_CTRL[1]) ##1 !hwdata[BIT_EN] |=> !drive.en[6]
  ) else $error("channel six not disabled after write of zero");

  a_phase_write: assert property (
    s_wr(IDX_SW_CTRL[1]) ##1 1'b1 |=> drive.phase[4] == $past(hwdata[BIT_PHASE])
  ) else $error("channel four phase not taken from write");

  // masked fault leaves status clear
  // Edge history and status count from channel two
  a_fault_masked: assert property (
    !st.cfg.unmask[4] && flt_f[4] && !st.flt_prev[2] && !st.stat[2]
      |=> !st.stat[2]
  ) else $error("masked fault set status");

  a_fault_unmask: assert property (
    st.cfg.unmask[4] && flt_f[4] && !st.flt_prev[2] |=> st.stat[2] ##1 1'b1
  ) else $error("unmasked fault lost");

  a_pg_read: assert property (
    s_rd(IDX_LDO_CTRL[0]) |=> hrdata[BIT_PG] == $past(pg_f[5])
  ) else $error("power-good bit does not match pin");

  a_discharge_off: assert property (
    s_quiet2 |-> drive.discharge == (st.cfg.dis & ~st.cfg.en[7:5])
  ) else $error("discharge active while channel on");

  a_ldo_ignore_sel: assert property (
    $changed(sel_f) && !st.wr_pend |=> $stable(drive.ldo_level)
  ) else $error("linear level moved with select pin");

  a_rsvd_level_zero: assert property (
    s_rd(IDX_SW_SEC[0]) |=> hrdata[31:6] == 26'h0
  ) else $error("reserved level bits read nonzero");

  a_rsvd_ctrl_zero: assert property (
    s_rd(IDX_SW_CTRL[1]) |=> hrdata[6:3] == 4'h0
  ) else $error("reserved control bits read nonzero");

  a_irq_level: assert property (
    s_quiet2 |-> irq == |(st.stat & st.mask)
  ) else $error("interrupt does not follow status and mask");

  a_stat_rd_clear: assert property (
    s_rd(IDX_IRQ_STAT) ##0 (flt_ev == 6'h00) |=> st.stat == 6'h00
  ) else $error("status not cleared by read");

  a_ready_okay: assert property (
    hreadyout && !hresp
  ) else $error("slave stalled or answered error");

  a_ch2_en_write: assert property (
    s_wr(IDX_CH2_CTRL) ##1 1'b1 |=> drive.en[2] == $past(hwdata[BIT_EN])
  ) else $error("channel two enable not taken from write");

  a_pri_code_write: assert property (
    s_wr(IDX_SW_PRI[1]) ##1 1'b1 |=> st.cfg.prim[1] == $past(hwdata[LVL_W-1:0])
  ) else $error("channel four primary code not stored");

  a_sec_level_ch3: assert property (
    sel_f [*2] |-> drive.sw_level[0] == st.cfg.sec[0]
  ) else $error("channel three secondary level not applied");

  a_unmask_write: assert property (
    s_wr(IDX_SW_CTRL[0]) ##1 1'b1 |=> st.cfg.unmask[3] == $past(hwdata[BIT_UNMASK])
  ) else $error("channel three unmask not taken from write");

  a_pg_ch2_read: assert property (
    s_rd(IDX_CH2_CTRL) |=> hrdata[BIT_PG] == $past(pg_f[2])
  ) else $error("channel two power-good bit does not match pin");

  a_dis_write: assert property (
    s_wr(IDX_LDO_CTRL[0]) ##1 1'b1 |=> st.cfg.dis[5] == $past(hwdata[BIT_DIS])
  ) else $error("channel five discharge bit not taken from write");

  a_ldo_code_write: assert property (
    s_wr(IDX_LDO_LVL[2]) ##1 1'b1 |=> drive.ldo_level[2] == $past(hwdata[LVL_W-1:0])
  ) else $error("channel seven level not applied from write");

  a_unmapped_zero: assert property (
    s_rd(8'hff) |=> hrdata == 32'h00000000
  ) else $error("unmapped read returned nonzero");

  // Status only drops on a read
  a_stat_sticky: assert property (
    !addr_take |=> (st.stat & $past(st.stat)) == $past(st.stat)
  ) else $error("status bit lost without a read");

  a_irq_masked_low: assert property (
    st.mask == 6'h00 && !st.wr_pend |=> !irq
  ) else $error("interrupt raised with every source masked");

endmodule : rcr_regs
`default_nettype wire

/* rtl/rcr_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module rcr_sync
  import rcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [RCR_SYNC_W-1:0] pin_in,
  output logic [RCR_SYNC_W-1:0] level_out
);

  rcr_sync_t st;
  rcr_sync_t nxt_st;

  always_comb begin
    nxt_st = st;
    nxt_st.s1 = pin_in;
    // s1 feeds s2 only; metastable stage stays private
    nxt_st.s2 = st.s1;
    nxt_st.s3 = st.s2;
    for (int i = 0; i < RCR_SYNC_W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        nxt_st.stable[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= {4{{RCR_SYNC_W{RST_SYNC}}}};
    end else begin
      st <= nxt_st;
    end
  end

  assign level_out = st.stable;

endmodule : rcr_sync
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the regulator control register bank
`timescale 1ns/100ps
`default_nettype none
module tb
  import rcr_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic level_select_pin = 1'b0;
  logic [7:2] pgood_pin = 6'h00;
  logic [7:2] fault_pin = 6'h00;
  rcr_drive_t drive;
  logic irq;
  int bad_count = 0;
  int samples_checked = 0;
  logic [7:0] all_idx [13] = '{IDX_CH2_CTRL, IDX_SW_PRI[0], IDX_SW_SEC[0], IDX_SW_CTRL[0],
    IDX_SW_PRI[1], IDX_SW_SEC[1], IDX_SW_CTRL[1], IDX_LDO_LVL[0], IDX_LDO_CTRL[0],
    IDX_LDO_LVL[1], IDX_LDO_CTRL[1], IDX_LDO_LVL[2], IDX_LDO_CTRL[2]};

  rcr_regs u_rcr_regs (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .level_select_pin(level_select_pin), .pgood_pin(pgood_pin), .fault_pin(fault_pin),
    .drive(drive), .irq(irq));

  always #50 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // Single AHB-Lite word transfer; waits on ready, never on a fixed count
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'b00};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? wd : 32'h0;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, idx, d, dummy);
    // Outputs update on the data-phase edge; look one edge later
    @(posedge clk);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, idx, 32'h0, v);
    check(v, exp, "read data");
    check({31'h0, hresp}, 32'h0, "response");
  endtask : rd_chk

  // Pins pass a filtering synchroniser, so allow a margin
  task automatic settle();
    repeat (10) @(posedge clk);
  endtask : settle

  task automatic t_reset();
    foreach (all_idx[i]) rd_chk(all_idx[i], 32'h0);
    $display("reset values done");
  endtask : t_reset

  task automatic t_switcher();
    wr(IDX_SW_CTRL[0], 32'hffff_ffff);
    rd_chk(IDX_SW_CTRL[0], 32'h86);
    check(32'(drive.en[3]), 32'h1, "enable");
    check(32'(drive.phase[3]), 32'h1, "phase");
    wr(IDX_SW_CTRL[0], 32'h02);
    check(32'({drive.en[3], drive.phase[3]}), 32'h0, "off");
    wr(IDX_CH2_CTRL, 32'h86);
    rd_chk(IDX_CH2_CTRL, 32'h86);
    check(32'({drive.en[2], drive.phase[2]}), 32'h3, "channel two");
    wr(IDX_SW_PRI[0], 32'hd5);
    wr(IDX_SW_SEC[0], 32'h2a);
    wr(IDX_SW_PRI[1], 32'h11);
    wr(IDX_SW_SEC[1], 32'h62);
    rd_chk(IDX_SW_PRI[0], 32'h15);
    check(32'(drive.sw_level[0]), 32'h15, "primary");
    check(32'(drive.sw_level[1]), 32'h11, "primary four");
    level_select_pin <= 1'b1;
    settle();
    check(32'(drive.sw_level[0]), 32'h2a, "secondary");
    check(32'(drive.sw_level[1]), 32'h22, "secondary four");
    level_select_pin <= 1'b0;
    settle();
    check(32'(drive.sw_level[0]), 32'h15, "primary again");
    check(32'(drive.sw_level[1]), 32'h11, "primary four again");
    $display("switcher test done");
  endtask : t_switcher

  task automatic t_linear();
    wr(IDX_LDO_LVL[2], 32'h3f);
    level_select_pin <= 1'b1;
    settle();
    check(32'(drive.ldo_level[2]), 32'h3f, "single level");
    level_select_pin <= 1'b0;
    wr(IDX_LDO_CTRL[0], 32'h05);
    check(32'(drive.discharge[5]), 32'h1, "discharge off");
    wr(IDX_LDO_CTRL[0], 32'h84);
    check(32'(drive.discharge[5]), 32'h0, "discharge on");
    wr(IDX_LDO_CTRL[1], 32'h80);
    check(32'(drive.en[6]), 32'h1, "channel six on");
    wr(IDX_LDO_CTRL[1], 32'h00);
    check(32'(drive.en[6]), 32'h0, "channel six off");
    pgood_pin[5] <= 1'b1;
    settle();
    rd_chk(IDX_LDO_CTRL[0], 32'h85);
    pgood_pin[5] <= 1'b0;
    settle();
    rd_chk(IDX_LDO_CTRL[0], 32'h84);
    wr(8'hff, 32'hff);
    rd_chk(8'hff, 32'h0);
    $display("linear test done");
  endtask : t_linear

  task automatic t_fault();
    wr(IDX_IRQ_MASK, 32'h3f);
    rd_chk(IDX_IRQ_MASK, 32'h3f);
    fault_pin[4] <= 1'b1;
    settle();
    check(32'(irq), 32'h0, "suppressed irq");
    rd_chk(IDX_IRQ_STAT, 32'h0);
    fault_pin[4] <= 1'b0;
    wr(IDX_SW_CTRL[1], 32'h02);
    settle();
    fault_pin[4] <= 1'b1;
    settle();
    check(32'(irq), 32'h1, "raised irq");
    rd_chk(IDX_IRQ_STAT, 32'h04);
    rd_chk(IDX_IRQ_STAT, 32'h0);
    check(32'(irq), 32'h0, "cleared irq");
    // Masked event still latches status but keeps irq low
    wr(IDX_IRQ_MASK, 32'h0);
    fault_pin[4] <= 1'b0;
    settle();
    fault_pin[4] <= 1'b1;
    settle();
    check(32'(irq), 32'h0, "masked irq");
    rd_chk(IDX_IRQ_STAT, 32'h04);
    $display("fault test done");
  endtask : t_fault

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_switcher();
    t_linear();
    t_fault();
    finish_test();
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
